/* hw/cgm_pkg.sv */
// Package for the capacitor gauge mode and learning parameter block
package cgm_pkg;
	// Printed offsets (not all multiples of four): register index, byte addr = 4*index
	localparam logic [7:0] IDX_DSG_THR   = 8'h00;
	localparam logic [7:0] IDX_CHG_THR   = 8'h02;
	localparam logic [7:0] IDX_QUIT_CUR  = 8'h04;
	localparam logic [7:0] IDX_VCHG0     = 8'h06;
	localparam logic [7:0] IDX_VCHG1     = 8'h08;
	localparam logic [7:0] IDX_VCHG2     = 8'h0A;
	localparam logic [7:0] IDX_VCHG3     = 8'h0C;
	localparam logic [7:0] IDX_FLOOR     = 8'h10;
	localparam logic [7:0] IDX_LEARN_WK  = 8'h12;
	// Own block for registers sharing printed offsets with others
	localparam logic [7:0] IDX_LEARN_TMO = 8'h20;
	localparam logic [7:0] IDX_GAIN      = 8'h21;
	localparam logic [7:0] IDX_CHARGE_SCALE_DELTA  = 8'h22;
	localparam logic [7:0] IDX_DEADBAND  = 8'h23;
	localparam logic [7:0] IDX_CURRENT   = 8'h24;
	localparam logic [7:0] IDX_TEMP      = 8'h25;
	localparam logic [7:0] IDX_CTRL      = 8'h26;
	localparam logic [7:0] IDX_STATUS    = 8'h27;
	localparam logic [7:0] IDX_CHARGE    = 8'h28;
	// Reset values
	localparam logic [15:0] RST_DSG_THR   = 16'h000A;
	localparam logic [15:0] RST_CHG_THR   = 16'h0000;
	localparam logic [15:0] RST_QUIT_CUR  = 16'h0000;
	localparam logic [15:0] RST_LEARN_TMO = 16'h000A;
	localparam logic [15:0] RST_VCHG0     = 16'h28A0;
	localparam logic [15:0] RST_VCHG1     = 16'h2B75;
	localparam logic [15:0] RST_VCHG2     = 16'h2E63;
	// Printed default 125000 exceeds 16 bits; held at the 25000 limit
	localparam logic [15:0] RST_VCHG3     = 16'h61A8;
	localparam logic [15:0] RST_FLOOR     = 16'h0FA0;
	localparam logic [7:0]  RST_LEARN_WK  = 8'h02;
	localparam logic [15:0] RST_DEADBAND  = 16'h0000;
	localparam logic [31:0] RST_GAIN      = 32'h3F711FF3; // 0.9419 single
	localparam logic [31:0] RST_CHARGE_SCALE_DELTA  = 32'h48892C9A; // 280932.825 single
	// Value limits
	localparam logic [15:0] MAX_VCHG      = 16'h61A8;
	localparam logic [15:0] MAX_TMO       = 16'h7FFF;
	localparam logic [15:0] MAX_FLOOR     = 16'h2710;
	localparam logic [15:0] MAX_THR       = 16'h07D0;
	localparam logic [15:0] MAX_QUIT      = 16'h03E8;
	// Temperature window, whole degrees C, signed
	localparam logic signed [15:0] TEMP_LO = 16'sh0005;
	localparam logic signed [15:0] TEMP_HI = 16'sh002D;
	// Timing
	localparam int CLK_HZ        = 200_000_000;
	localparam int QUAL_S        = 60;
	localparam int IDLE_S        = 5;
	localparam int SEC_PER_WEEK  = 604800;
	// Control fields
	localparam int CTRL_LEARN_GO = 0;
	localparam int CTRL_CAL_DONE = 1;

	typedef enum logic [2:0] {
		CGM_RELAX = 3'b001,
		CGM_CHG   = 3'b010,
		CGM_DSG   = 3'b100
	} cgm_mode_e;

	typedef enum logic [1:0] {
		LRN_IDLE = 2'b01,
		LRN_RUN  = 2'b10
	} cgm_lrn_e;

	typedef struct packed {
		logic [15:0] dsg_thr;
		logic [15:0] chg_thr;
		logic [15:0] quit_cur;
		logic [15:0] learn_tmo;
		logic [15:0] vchg0;
		logic [15:0] vchg1;
		logic [15:0] vchg2;
		logic [15:0] vchg3;
		logic [15:0] floor_v;
		logic [7:0]  learn_wk;
		logic [31:0] gain;
		logic [31:0] charge_scale_delta;
		logic [15:0] deadband;
	} cgm_params_s;
endpackage : cgm_pkg

/* hw/cgm_top.sv */
// Mode tracking, learning schedule, deadband and auto-calibration control
// Contract
// R1: Both selects low picks level 0
// R2: Hi low, lo high picks level 1
// R3: Hi high, lo low picks level 2
// R4: Both high picks level 3; limit 25000
// R5: Learning cycle bounded by timeout seconds
// R6: Usage floor voltage, limited 10000
// R7: Learning starts every interval weeks
// R8: Charge to discharge below minus threshold
// R9: Discharge to charge above threshold
// R10: Charge to relax after 60s below quit
// R11: Discharge to relax after 60s above minus quit
// R12: No accumulation inside deadband
// R13: Calibrate after 5s bus low, 5..45C
// R14: Current gain scale parameter held
// R15: Charge delta scale parameter held
// R16: Defaults usable without calibration
// R17: Qualification timer restarts on recrossing
// R18: Idle timer resets; temperature gates calibration
`timescale 1ns/100ps
`default_nettype none
module cgm_top
	import cgm_pkg::*;
#(
	parameter int SEC_CYCLES = CLK_HZ
) (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               charge_level_select_hi,
	input  wire logic               charge_level_select_lo,
	input  wire logic               smb_clk_in,
	input  wire logic               smb_data_in,
	output logic      [15:0]        charge_target_mv,
	output logic      [2:0]         mode,
	output logic                    learning_active,
	output logic                    cal_active
);
	import cgm_pkg::*;

	localparam int QUAL_CYC = QUAL_S;
	localparam int IDLE_CYC = IDLE_S;

	typedef struct packed {
		cgm_params_s  p;
		logic signed [15:0] current;
		logic signed [15:0] temp;
		logic [31:0]  sec_cnt;
		logic         sec_tick;
		logic [7:0]   qual_s;
		logic [3:0]   idle_s;
		logic [19:0]  week_s;
		logic [7:0]   weeks;
		logic [15:0]  lrn_s;
		cgm_lrn_e     lrn;
		cgm_mode_e    md;
		logic         cal;
		logic signed [31:0] charge;
		logic         ph_valid;
		logic         ph_write;
		logic [7:0]   ph_idx;
		logic [31:0]  rdata;
		logic [15:0]  target;
	} cgm_state_s;

	cgm_state_s st_reg;
	cgm_state_s st_next;

	// Clamp a written value to its documented range
	function automatic logic [15:0] cgm_clamp(input logic [15:0] v, input logic [15:0] lim);
		cgm_clamp = (v > lim) ? lim : v;
	endfunction

	// Magnitude of a signed current sample
	function automatic logic [15:0] cgm_abs(input logic signed [15:0] v);
		cgm_abs = v[15] ? 16'(-v) : 16'(v);
	endfunction

	logic signed [16:0] neg_dsg;
	logic signed [16:0] neg_quit;
	logic signed [16:0] cur_x;
	logic               bus_low;
	logic               temp_ok;
	logic               addr_ok;

	always_comb begin
		cur_x    = 17'(st_reg.current);
		neg_dsg  = -17'(signed'({1'b0, st_reg.p.dsg_thr}));
		neg_quit = -17'(signed'({1'b0, st_reg.p.quit_cur}));
		bus_low  = !smb_clk_in && !smb_data_in;
		temp_ok  = (st_reg.temp >= TEMP_LO) && (st_reg.temp <= TEMP_HI);
		addr_ok  = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);
	end

	// Next-state logic for every part of the block
	always_comb begin
		st_next = st_reg;
		st_next.sec_tick = 1'b0;

		// One-second enable pulse from the clock divider
		if (st_reg.sec_cnt == 32'(SEC_CYCLES - 1)) begin
			st_next.sec_cnt  = 32'h0;
			st_next.sec_tick = 1'b1;
		end else begin
			st_next.sec_cnt = st_reg.sec_cnt + 32'h1;
		end

		// R1 R2 R3 R4 select level by pins
		case ({charge_level_select_hi, charge_level_select_lo})
			2'b00: st_next.target = st_reg.p.vchg0;
			2'b01: st_next.target = st_reg.p.vchg1;
			2'b10: st_next.target = st_reg.p.vchg2;
			default: st_next.target = st_reg.p.vchg3;
		endcase

		// Mode tracking; relaxation leaves on any threshold crossing
		case (st_reg.md)
			CGM_CHG: begin
				// R8 enter discharge
				if (cur_x < neg_dsg) begin
					st_next.md     = CGM_DSG;
					st_next.qual_s = 8'h0;
				// R10 R17 quit qualification
				end else if (cur_x < 17'(signed'({1'b0, st_reg.p.quit_cur}))) begin
					if (st_reg.sec_tick) begin
						st_next.qual_s = st_reg.qual_s + 8'h1;
					end
					if (st_reg.qual_s >= 8'(QUAL_CYC)) begin
						st_next.md     = CGM_RELAX;
						st_next.qual_s = 8'h0;
					end
				end else begin
					st_next.qual_s = 8'h0;
				end
			end
			CGM_DSG: begin
				// R9 enter charge
				if (cur_x > 17'(signed'({1'b0, st_reg.p.chg_thr}))) begin
					st_next.md     = CGM_CHG;
					st_next.qual_s = 8'h0;
				// R11 R17 quit qualification
				end else if (cur_x > neg_quit) begin
					if (st_reg.sec_tick) begin
						st_next.qual_s = st_reg.qual_s + 8'h1;
					end
					if (st_reg.qual_s >= 8'(QUAL_CYC)) begin
						st_next.md     = CGM_RELAX;
						st_next.qual_s = 8'h0;
					end
				end else begin
					st_next.qual_s = 8'h0;
				end
			end
			default: begin
				st_next.qual_s = 8'h0;
				if (cur_x > 17'(signed'({1'b0, st_reg.p.chg_thr}))) begin
					st_next.md = CGM_CHG;
				end else if (cur_x < neg_dsg) begin
					st_next.md = CGM_DSG;
				end
			end
		endcase

		// R12 deadband gates accumulation
		if (st_reg.sec_tick && (cgm_abs(st_reg.current) >= st_reg.p.deadband)) begin
			st_next.charge = st_reg.charge + 32'(st_reg.current);
		end

		// R13 R18 idle-low timer and temperature gate
		if (!bus_low) begin
			st_next.idle_s = 4'h0;
		end else if (st_reg.sec_tick && st_reg.idle_s < 4'(IDLE_CYC)) begin
			st_next.idle_s = st_reg.idle_s + 4'h1;
		end
		if (bus_low && temp_ok && st_reg.idle_s >= 4'(IDLE_CYC)) begin
			st_next.cal = 1'b1;
		end

		// R7 week counter starts learning cycles
		if (st_reg.sec_tick) begin
			if (st_reg.week_s == 20'(SEC_PER_WEEK - 1)) begin
				st_next.week_s = 20'h0;
				st_next.weeks  = st_reg.weeks + 8'h1;
			end else begin
				st_next.week_s = st_reg.week_s + 20'h1;
			end
		end
		case (st_reg.lrn)
			LRN_IDLE: begin
				st_next.lrn_s = 16'h0;
				if (st_reg.p.learn_wk != 8'h0 && st_reg.weeks >= st_reg.p.learn_wk) begin
					st_next.lrn   = LRN_RUN;
					st_next.weeks = 8'h0;
				end
			end
			default: begin
				// R5 timeout ends cycle
				if (st_reg.sec_tick) begin
					st_next.lrn_s = st_reg.lrn_s + 16'h1;
				end
				if (st_reg.lrn_s >= st_reg.p.learn_tmo) begin
					st_next.lrn = LRN_IDLE;
				end
			end
		endcase

		// Bus data phase: write, then capture the next address phase
		st_next.rdata = 32'h0;
		if (st_reg.ph_valid && st_reg.ph_write) begin
			if (st_reg.ph_idx == IDX_DSG_THR) begin
				st_next.p.dsg_thr = cgm_clamp(hwdata[15:0], MAX_THR);
			end else if (st_reg.ph_idx == IDX_CHG_THR) begin
				st_next.p.chg_thr = cgm_clamp(hwdata[15:0], MAX_THR);
			end else if (st_reg.ph_idx == IDX_QUIT_CUR) begin
				st_next.p.quit_cur = cgm_clamp(hwdata[15:0], MAX_QUIT);
			end else if (st_reg.ph_idx == IDX_VCHG0) begin
				// R4 voltage range limit
				st_next.p.vchg0 = cgm_clamp(hwdata[15:0], MAX_VCHG);
			end else if (st_reg.ph_idx == IDX_VCHG1) begin
				st_next.p.vchg1 = cgm_clamp(hwdata[15:0], MAX_VCHG);
			end else if (st_reg.ph_idx == IDX_VCHG2) begin
				st_next.p.vchg2 = cgm_clamp(hwdata[15:0], MAX_VCHG);
			end else if (st_reg.ph_idx == IDX_VCHG3) begin
				st_next.p.vchg3 = cgm_clamp(hwdata[15:0], MAX_VCHG);
			end else if (st_reg.ph_idx == IDX_FLOOR) begin
				// R6 floor limit
				st_next.p.floor_v = cgm_clamp(hwdata[15:0], MAX_FLOOR);
			end else if (st_reg.ph_idx == IDX_LEARN_WK) begin
				st_next.p.learn_wk = hwdata[7:0];
			end else if (st_reg.ph_idx == IDX_LEARN_TMO) begin
				st_next.p.learn_tmo = cgm_clamp(hwdata[15:0], MAX_TMO);
			end else if (st_reg.ph_idx == IDX_GAIN) begin
				// R14 gain stored
				st_next.p.gain = hwdata;
			end else if (st_reg.ph_idx == IDX_CHARGE_SCALE_DELTA) begin
				// R15 delta stored
				st_next.p.charge_scale_delta = hwdata;
			end else if (st_reg.ph_idx == IDX_DEADBAND) begin
				st_next.p.deadband = hwdata[15:0];
			end else if (st_reg.ph_idx == IDX_CURRENT) begin
				st_next.current = hwdata[15:0];
			end else if (st_reg.ph_idx == IDX_TEMP) begin
				st_next.temp = hwdata[15:0];
			end else if (st_reg.ph_idx == IDX_CTRL) begin
				if (hwdata[CTRL_LEARN_GO]) begin
					st_next.lrn = LRN_RUN;
				end
				// A new idle request wins over the clear
				if (hwdata[CTRL_CAL_DONE] && !(bus_low && temp_ok
						&& st_reg.idle_s >= 4'(IDLE_CYC))) begin
					st_next.cal = 1'b0;
				end
			end
		end
		st_next.ph_valid = hsel && hready && htrans[1];
		st_next.ph_write = hwrite;
		st_next.ph_idx   = addr_ok ? haddr[9:2] : 8'hFF;
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (haddr[9:2] == IDX_DSG_THR) begin
				st_next.rdata = {16'h0, st_reg.p.dsg_thr};
			end else if (haddr[9:2] == IDX_CHG_THR) begin
				st_next.rdata = {16'h0, st_reg.p.chg_thr};
			end else if (haddr[9:2] == IDX_QUIT_CUR) begin
				st_next.rdata = {16'h0, st_reg.p.quit_cur};
			end else if (haddr[9:2] == IDX_VCHG0) begin
				st_next.rdata = {16'h0, st_reg.p.vchg0};
			end else if (haddr[9:2] == IDX_VCHG1) begin
				st_next.rdata = {16'h0, st_reg.p.vchg1};
			end else if (haddr[9:2] == IDX_VCHG2) begin
				st_next.rdata = {16'h0, st_reg.p.vchg2};
			end else if (haddr[9:2] == IDX_VCHG3) begin
				st_next.rdata = {16'h0, st_reg.p.vchg3};
			end else if (haddr[9:2] == IDX_FLOOR) begin
				st_next.rdata = {16'h0, st_reg.p.floor_v};
			end else if (haddr[9:2] == IDX_LEARN_WK) begin
				st_next.rdata = {24'h0, st_reg.p.learn_wk};
			end else if (haddr[9:2] == IDX_LEARN_TMO) begin
				st_next.rdata = {16'h0, st_reg.p.learn_tmo};
			end else if (haddr[9:2] == IDX_GAIN) begin
				st_next.rdata = st_reg.p.gain;
			end else if (haddr[9:2] == IDX_CHARGE_SCALE_DELTA) begin
				st_next.rdata = st_reg.p.charge_scale_delta;
			end else if (haddr[9:2] == IDX_DEADBAND) begin
				st_next.rdata = {16'h0, st_reg.p.deadband};
			end else if (haddr[9:2] == IDX_CURRENT) begin
				st_next.rdata = {16'h0, st_reg.current};
			end else if (haddr[9:2] == IDX_TEMP) begin
				st_next.rdata = {16'h0, st_reg.temp};
			end else if (haddr[9:2] == IDX_STATUS) begin
				st_next.rdata = {16'h0, st_reg.target[7:0], 3'h0,
					st_reg.cal, st_reg.lrn == LRN_RUN, st_reg.md};
			end else if (haddr[9:2] == IDX_CHARGE) begin
				st_next.rdata = st_reg.charge;
			end
			if (!addr_ok) begin
				st_next.rdata = 32'h0;
			end
		end
	end

	// R16 register defaults are usable values
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '{p: '{dsg_thr: RST_DSG_THR, chg_thr: RST_CHG_THR,
				quit_cur: RST_QUIT_CUR, learn_tmo: RST_LEARN_TMO,
				vchg0: RST_VCHG0, vchg1: RST_VCHG1, vchg2: RST_VCHG2,
				vchg3: RST_VCHG3, floor_v: RST_FLOOR, learn_wk: RST_LEARN_WK,
				gain: RST_GAIN, charge_scale_delta: RST_CHARGE_SCALE_DELTA, deadband: RST_DEADBAND},
				lrn: LRN_IDLE, md: CGM_RELAX, target: RST_VCHG0, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from state flops; zero wait state, always OKAY
	always_comb begin
		hrdata           = st_reg.rdata;
		hreadyout        = 1'b1;
		hresp            = 1'b0;
		charge_target_mv = st_reg.target;
		mode             = st_reg.md;
		learning_active  = st_reg.lrn == LRN_RUN;
		cal_active       = st_reg.cal;
	end
endmodule // cgm_top
`default_nettype wire

/* verif/cgm_top_props.sv */
// Concurrent checks on the mode and learning parameter block ports
`timescale 1ns/100ps
`default_nettype none
module cgm_top_props
	import cgm_pkg::*;
#(
	parameter int SEC_CYCLES = CLK_HZ
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        smb_clk_in,
	input wire logic        smb_data_in,
	input wire logic [15:0] charge_target_mv,
	input wire logic [2:0]  mode,
	input wire logic        learning_active,
	input wire logic        cal_active
);
	logic       rd_ph;
	logic       wr_ph;
	logic [2:0] mode_q;
	int         idle_cnt;
	longint     mode_cnt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Data phase flags, idle run length and time spent in one mode
	always_ff @(posedge mclk) begin
		rd_ph    <= !rst && hsel && hready && htrans[1] && !hwrite;
		wr_ph    <= !rst && hsel && hready && htrans[1] && hwrite;
		idle_cnt <= (rst || smb_clk_in || smb_data_in) ? 0 : idle_cnt + 1;
		mode_q   <= mode;
		mode_cnt <= (rst || mode != mode_q) ? 1 : mode_cnt + 1;
	end

	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("slave not ready or not okay");

	property p_rst_state;
		$past(rst) |-> mode == CGM_RELAX && !cal_active && !learning_active;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("bad state after reset");

	property p_onehot;
		$onehot(mode);
	endproperty
	a_onehot: assert property (p_onehot) else $error("mode not one-hot");

	property p_limit;
		charge_target_mv <= 16'h61A8;
	endproperty
	a_limit: assert property (p_limit) else $error("target above limit");

	property p_relax_qual;
		mode == CGM_RELAX && mode_q != CGM_RELAX |-> mode_cnt >= 59 * longint'(SEC_CYCLES);
	endproperty
	a_relax_qual: assert property (p_relax_qual) else $error("relax too early");

	property p_cal_idle;
		$rose(cal_active) |-> idle_cnt >= 4 * SEC_CYCLES;
	endproperty
	a_cal_idle: assert property (p_cal_idle) else $error("cal without idle bus");

	property p_cal_drop;
		$fell(cal_active) && !$past(rst) |-> $past(wr_ph);
	endproperty
	a_cal_drop: assert property (p_cal_drop) else $error("cal dropped without write");

	property p_rd_quiet;
		!rd_ph |-> hrdata == 32'h0;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside data phase");
endmodule // cgm_top_props

bind cgm_top cgm_top_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (
	.mclk(mclk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.smb_clk_in(smb_clk_in), .smb_data_in(smb_data_in),
	.charge_target_mv(charge_target_mv), .mode(mode),
	.learning_active(learning_active), .cal_active(cal_active)
);
`default_nettype wire

/* verif/cgm_host_model.sv */
// Host controller seen only as its two bus line levels
`timescale 1ns/100ps
`default_nettype none
module cgm_host_model (
	input  wire logic mclk,
	input  wire logic busy,
	output logic      smb_clk,
	output logic      smb_data
);
	// busy host toggles, idle host holds both lines low
	always_ff @(posedge mclk) begin
		smb_clk  <= busy & !smb_clk;
		smb_data <= busy;
	end
endmodule // cgm_host_model
`default_nettype wire

/* verif/cgm_top_tb.sv */
// Testbench for the mode and learning parameter block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module cgm_top_tb;
	import cgm_pkg::*;
	localparam int SC = 4;
	logic        mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic        lvl_hi, lvl_lo, busy, smb_clk, smb_data, learn, cal;
	logic [31:0] haddr, hwdata, hrdata, q, c1;
	logic [1:0]  htrans;
	logic [2:0]  hsize, mode;
	logic [15:0] tgt;
	logic [7:0]  ix [13];
	logic [31:0] ev [13];
	logic [15:0] vt [4];
	int          mismatches, checked;

	// One slave, so its ready is the bus ready
	assign hready = hreadyout;

	cgm_top #(.SEC_CYCLES(SC)) uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.charge_level_select_hi(lvl_hi), .charge_level_select_lo(lvl_lo),
		.smb_clk_in(smb_clk), .smb_data_in(smb_data), .charge_target_mv(tgt),
		.mode(mode), .learning_active(learn), .cal_active(cal));

	cgm_host_model u_host (.mclk(mclk), .busy(busy), .smb_clk(smb_clk), .smb_data(smb_data));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Single word transfer; waits on ready, data taken at the closing edge
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h000000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		q = hrdata;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		`CHK($sformatf("reg %0h", idx), e, q)
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic test_done;
		$display("Checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		wt(8000);
		mismatches++;
		test_done;
	end

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		lvl_hi = 1'b0;
		lvl_lo = 1'b0;
		busy = 1'b0;
		mismatches = 0;
		checked = 0;
		ix = '{IDX_DSG_THR, IDX_CHG_THR, IDX_QUIT_CUR, IDX_LEARN_TMO, IDX_VCHG0, IDX_VCHG1,
			IDX_VCHG2, IDX_VCHG3, IDX_FLOOR, IDX_LEARN_WK, IDX_GAIN, IDX_CHARGE_SCALE_DELTA, 8'h30};
		ev = '{32'(RST_DSG_THR), 32'(RST_CHG_THR), 32'(RST_QUIT_CUR), 32'(RST_LEARN_TMO),
			32'(RST_VCHG0), 32'(RST_VCHG1), 32'(RST_VCHG2), 32'(RST_VCHG3), 32'(RST_FLOOR),
			32'(RST_LEARN_WK), RST_GAIN, RST_CHARGE_SCALE_DELTA, 32'h0};
		vt = '{RST_VCHG0, RST_VCHG1, RST_VCHG2, RST_VCHG3};
		wt(4);
		rst <= 1'b0;
		// Reset values, unmapped place last
		for (int i = 0; i < 13; i++) rd(ix[i], ev[i]);
		// Every level select combination
		for (int p = 0; p < 4; p++) begin
			lvl_hi <= p[1];
			lvl_lo <= p[0];
			wt(2);
			`CHK("target", vt[p], tgt)
		end
		bus(1'b1, IDX_VCHG3, 32'h0000FFFF);
		rd(IDX_VCHG3, 32'h000061A8);
		bus(1'b1, IDX_VCHG3, 32'h00001234);
		wt(2);
		`CHK("target", 16'h1234, tgt)
		// Mode entry by thresholds
		bus(1'b1, IDX_CURRENT, 32'h0000012C);
		bus(1'b1, IDX_CURRENT, 32'h0000FFF5);
		wt(3);
		`CHK("mode", CGM_DSG, mode)
		bus(1'b1, IDX_CURRENT, 32'h0000012C);
		wt(3);
		`CHK("mode", CGM_CHG, mode)
		// Quit qualification with a recrossing in mid count
		bus(1'b1, IDX_CHG_THR, 32'h000000C8);
		bus(1'b1, IDX_QUIT_CUR, 32'h00000064);
		bus(1'b1, IDX_CURRENT, 32'h00000032);
		wt(30 * SC);
		bus(1'b1, IDX_CURRENT, 32'h00000096);
		bus(1'b1, IDX_CURRENT, 32'h00000032);
		wt(58 * SC);
		`CHK("mode", CGM_CHG, mode)
		wt(4 * SC);
		`CHK("mode", CGM_RELAX, mode)
		bus(1'b1, IDX_CURRENT, 32'h0000FFF5);
		bus(1'b1, IDX_CURRENT, 32'h0000FFFB);
		wt(62 * SC);
		`CHK("mode", CGM_RELAX, mode)
		// Accumulator held inside the deadband only
		bus(1'b1, IDX_DEADBAND, 32'h00000064);
		bus(1'b1, IDX_CURRENT, 32'h00000032);
		bus(1'b0, IDX_CHARGE, 32'h0);
		c1 = q;
		wt(5 * SC);
		rd(IDX_CHARGE, c1);
		bus(1'b1, IDX_CURRENT, 32'h00000096);
		wt(3 * SC);
		bus(1'b0, IDX_CHARGE, 32'h0);
		`CHK("accum moved", 1'b1, q !== c1)
		// Idle timer restarts on bus activity, then calibrates; bus busy before temp is valid
		busy <= 1'b1;
		bus(1'b1, IDX_TEMP, 32'h00000019);
		wt(3 * SC);
		busy <= 1'b0;
		wt(3 * SC);
		busy <= 1'b1;
		wt(1);
		busy <= 1'b0;
		wt(3 * SC);
		`CHK("cal", 1'b0, cal)
		wt(4 * SC);
		`CHK("cal", 1'b1, cal)
		rd(IDX_STATUS, 32'h00003411);
		// Too hot: cleared and stays off
		bus(1'b1, IDX_TEMP, 32'h00000032);
		bus(1'b1, IDX_CTRL, 32'h00000002);
		wt(8 * SC);
		`CHK("cal", 1'b0, cal)
		// Learning bounded by its timeout
		bus(1'b1, IDX_LEARN_TMO, 32'h00000003);
		bus(1'b1, IDX_CTRL, 32'h00000001);
		wt(SC);
		`CHK("learning", 1'b1, learn)
		wt(4 * SC);
		`CHK("learning", 1'b0, learn)
		test_done;
	end
endmodule // cgm_top_tb
`default_nettype wire
